// ### rtl/abd_pkg.sv
// Purpose: Shared constants and types for the address-phase drive, snoop and parity block.
// Assumes: Bus pins are synchronous to clk_sys, which is the bus clock.
// Notes:   Address bit index i on every port carries bus address line i; line 0 is the most significant.
package abd_pkg;

	// ==========================================================
	// Widths
	localparam int ABD_ADDR_W     = 32;   // Address lines
	localparam int ABD_BYTE_W     = 8;    // Bits covered by one parity bit
	localparam int ABD_PAR_W      = ABD_ADDR_W / ABD_BYTE_W; // Parity lines
	localparam int ABD_TAG_W      = 4;    // Default processor tag width

	// ==========================================================
	// Field positions (line numbers, line 0 is the MSB)
	localparam int ABD_DW_LO_POS   = 29;  // Lines 29..31 cleared for double-word alignment
	localparam int ABD_LINE_LO_POS = 27;  // Lines 27..31 cleared for cache-line alignment
	localparam int ABD_RTAG_POS    = 28;  // First line of the receiver tag in beat 0

	// ==========================================================
	// Reset values of driven pins (active-low strobes idle high)
	localparam logic                  ABD_RST_STROBE = 1'h1;
	localparam logic                  ABD_RST_OE     = 1'h0;
	localparam logic [ABD_ADDR_W-1:0] ABD_RST_ADDR   = 32'h00000000;
	localparam logic [ABD_PAR_W-1:0]  ABD_RST_PAR    = 4'hF;

	// ==========================================================
	// Cycle counts
	localparam int ABD_APE_DELAY  = 2;    // Start strobe to parity error drive, in bus cycles

	// ==========================================================
	// Master tenure states
	typedef enum logic [2:0] {
		ABD_IDLE,       // Not master
		ABD_MEM_ADDR,   // Memory address driven, waiting acknowledge
		ABD_DS_BEAT0,   // Direct-store packet 0
		ABD_DS_BEAT1,   // Direct-store packet 1, waiting acknowledge
		ABD_RELEASE     // Outputs floated, busy driven negated
	} abd_state_t;

endpackage

// ### rtl/abd_odd_parity.sv
// Purpose: Per-byte odd parity generator and checker.
// Assumes: Byte k of the word is lines 8k..8k+7, matching parity line k.
// Notes:   Pure combinational; the caller registers what it drives.
module abd_odd_parity
	import abd_pkg::*;
#(
	parameter int WORD_W = ABD_ADDR_W   // Word width, whole bytes only
) (
	input  wire logic [0:WORD_W-1]            word,      // Word to cover
	input  wire logic [0:WORD_W/ABD_BYTE_W-1] parIn,     // Parity to check
	output logic      [0:WORD_W/ABD_BYTE_W-1] parOut,    // Generated odd parity
	output logic                              parBad     // Any byte plus parity even
);

	localparam int NB = WORD_W / ABD_BYTE_W; // Byte count

	// ==========================================================
	// Elaboration check
	if (WORD_W % ABD_BYTE_W != 0) begin : g_chk
		$error("abd_odd_parity: WORD_W must be whole bytes");
	end

	logic [0:NB-1] byteBad; // Per-byte check result

	// ==========================================================
	// One parity bit per byte
	for (genvar k = 0; k < NB; k++) begin : g_byte
		// Inverted XOR makes the byte plus parity odd
		assign parOut[k]  = ~(^word[k*ABD_BYTE_W +: ABD_BYTE_W]);
		// Even count over byte and received bit is an error
		assign byteBad[k] = ~(^{word[k*ABD_BYTE_W +: ABD_BYTE_W], parIn[k]});
	end

	assign parBad = |byteBad;

endmodule // abd_odd_parity

// ### rtl/abd_addr_phase.sv
// Purpose: Address-phase drive, snoop capture and address parity for a shared system bus.
// Assumes: Bus pins are synchronous to clk_sys; the pad ring resolves pins from out/oe pairs.
// Notes:   Strobes are active low; open-drain error pin is driven only while low.
module abd_addr_phase
	import abd_pkg::*;
#(
	parameter int TAG_W = ABD_TAG_W     // Processor tag width
) (
	input  wire logic                  clk_sys,        // Bus clock, 20 MHz
	input  wire logic                  resetn,         // Async reset, active low
	// Requester side
	input  wire logic                  reqValid,       // Tenure request pending
	input  wire logic                  reqDirect,      // 1: direct-store, 0: memory
	input  wire logic                  reqBurst,       // Memory burst transfer
	input  wire logic                  reqWrite,       // Memory write
	input  wire logic [0:ABD_ADDR_W-1] reqAddr,        // Physical address
	input  wire logic [0:ABD_ADDR_W-1] reqPacket0,     // Direct-store control and tag packet
	output logic                       reqReady,       // Request taken this edge
	output logic                       tenureDone,     // Own address tenure acknowledged
	input  wire logic [TAG_W-1:0]      processorTag,   // Own processor tag
	// Snoop results
	output logic                       snoopValid,     // Captured snoop, one cycle
	output logic                       snoopDirect,    // Snoop was a direct-store beat 0
	output logic                       snoopReplyHit,  // Direct-store reply tag matches own
	output logic [0:ABD_ADDR_W-1]      snoopAddr,      // Captured snoop address
	output logic                       snoopParErr,    // Captured beat had even parity
	// Bus pins
	input  wire logic                  bus_grant_n,    // Bus grant
	input  wire logic                  addr_ack_n,     // Address acknowledge
	input  wire logic                  addr_bus_busy_n_in,  // Busy pin level
	output logic                       addr_bus_busy_n_out, // Busy drive value
	output logic                       addr_bus_busy_n_oe,  // Busy drive enable
	input  wire logic                  xfer_start_n_in,     // Start pin level
	output logic                       xfer_start_n_out,    // Start drive value
	output logic                       xfer_start_n_oe,     // Start drive enable
	input  wire logic                  ext_xfer_start_n_in, // Extended start pin level
	output logic                       ext_xfer_start_n_out,// Extended start drive value
	output logic                       ext_xfer_start_n_oe, // Extended start drive enable
	input  wire logic [0:ABD_ADDR_W-1] addr_lines_in,      // Address pin levels
	output logic      [0:ABD_ADDR_W-1] addr_lines_out,     // Address drive value
	output logic                       addr_lines_oe,      // Address drive enable
	input  wire logic [0:ABD_PAR_W-1]  addr_byte_parity_in,  // Parity pin levels
	output logic      [0:ABD_PAR_W-1]  addr_byte_parity_out, // Parity drive value
	output logic                       addr_byte_parity_oe,  // Parity drive enable
	output logic                       addr_parity_err_n_out,// Error drive value, open drain
	output logic                       addr_parity_err_n_oe  // Error drive enable
);

	// ==========================================================
	// Elaboration check
	if (TAG_W < 1 || TAG_W > ABD_ADDR_W - ABD_RTAG_POS) begin : g_chk
		$error("abd_addr_phase: TAG_W does not fit the receiver tag field");
	end

	// ==========================================================
	// State record
	typedef struct packed {
		abd_state_t            st;        // Master tenure state
		logic [0:ABD_ADDR_W-1] addr;      // Driven address
		logic [0:ABD_PAR_W-1]  par;       // Driven parity
		logic                  addrOe;    // Address and parity enable
		logic [0:ABD_ADDR_W-1] beat1;     // Held direct-store address
		logic                  tsOut;     // Start value
		logic                  tsOe;      // Start enable
		logic                  xsOut;     // Extended start value
		logic                  xsOe;      // Extended start enable
		logic                  abbOut;    // Busy value
		logic                  abbOe;     // Busy enable
		logic                  othersTen; // Another master between start and ack
		logic                  capNow;    // Snoop captured last edge
		logic                  capDirect; // Capture was direct-store
		logic [0:ABD_ADDR_W-1] capAddr;   // Captured address
		logic [0:ABD_PAR_W-1]  capPar;    // Captured parity
		logic                  apeDrive;  // Error pin being pulled low
		logic                  done;      // Tenure done pulse
	} abd_regs_t;

	abd_regs_t r;       // Registered state
	abd_regs_t next_r;  // Next state

	// ==========================================================
	// Parity helpers
	logic [0:ABD_ADDR_W-1] driveWord;  // Word about to be driven
	logic [0:ABD_PAR_W-1]  drivePar;   // Its parity
	logic                  capBad;     // Captured word parity error

	abd_odd_parity #(.WORD_W(ABD_ADDR_W)) u_genPar (
		.word   (driveWord),
		.parIn  (ABD_RST_PAR),
		.parOut (drivePar),
		.parBad ()
	);

	abd_odd_parity #(.WORD_W(ABD_ADDR_W)) u_chkPar (
		.word   (r.capAddr),
		.parIn  (r.capPar),
		.parOut (),
		.parBad (capBad)
	);

	// ==========================================================
	// Grant qualification
	logic ackSeen;    // Acknowledge low this cycle
	logic otherStart; // Another master started a tenure
	logic qualGrant;  // Free to take the bus
	logic [0:ABD_ADDR_W-1] alignedAddr; // Memory address after burst alignment

	assign ackSeen    = ~addr_ack_n;
	assign otherStart = (~xfer_start_n_in & ~r.tsOe) | (~ext_xfer_start_n_in & ~r.xsOe);
	// Own busy drive never blocks; it floats in the same cycle the state is idle again
	// Busy from elsewhere, or a foreign tenure in flight, blocks the grant
	assign qualGrant  = ~bus_grant_n & (addr_bus_busy_n_in | r.abbOe) & ~r.othersTen
		& ~otherStart & (r.st == ABD_IDLE);
	assign reqReady   = reqValid & qualGrant;

	// ==========================================================
	// Burst alignment of the memory address
	always_comb begin
		alignedAddr = reqAddr;
		if (reqBurst) begin
			// Read: critical double word; write: start of the line
			for (int i = 0; i < ABD_ADDR_W; i++) begin
				if ((reqWrite && i >= ABD_LINE_LO_POS) || (!reqWrite && i >= ABD_DW_LO_POS)) begin
					alignedAddr[i] = 1'h0;
				end
			end
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_r      = r;
		next_r.done = 1'h0;
		driveWord   = r.addr;

		// Start strobes: assert one cycle, drive negated one cycle, then float
		if (r.tsOe && !r.tsOut) begin
			next_r.tsOut = 1'h1;
		end else if (r.tsOe) begin
			next_r.tsOe = 1'h0;
		end
		if (r.xsOe && !r.xsOut) begin
			next_r.xsOut = 1'h1;
		end else if (r.xsOe) begin
			next_r.xsOe = 1'h0;
		end

		unique case (r.st)
			ABD_IDLE: begin
				if (reqReady && !reqDirect) begin
					// Address, busy and start together, cycle after grant
					driveWord     = alignedAddr;
					next_r.addrOe = 1'h1;
					next_r.tsOut  = 1'h0;
					next_r.tsOe   = 1'h1;
					next_r.abbOut = 1'h0;
					next_r.abbOe  = 1'h1;
					next_r.st     = ABD_MEM_ADDR;
				end else if (reqReady) begin
					// Packet 0 with extended start; address kept for beat 1
					driveWord     = reqPacket0;
					next_r.beat1  = reqAddr;
					next_r.addrOe = 1'h1;
					next_r.xsOut  = 1'h0;
					next_r.xsOe   = 1'h1;
					next_r.abbOut = 1'h0;
					next_r.abbOe  = 1'h1;
					next_r.st     = ABD_DS_BEAT0;
				end
			end
			ABD_MEM_ADDR: begin
				// Address held, no increment across the burst
				if (ackSeen) begin
					next_r.st = ABD_RELEASE;
				end
			end
			ABD_DS_BEAT0: begin
				// Always one cycle, whatever acknowledge does
				driveWord = r.beat1;
				next_r.st = ABD_DS_BEAT1;
			end
			ABD_DS_BEAT1: begin
				if (ackSeen) begin
					next_r.st = ABD_RELEASE;
				end
			end
			ABD_RELEASE: begin
				// Busy goes quiet after its negated cycle
				next_r.abbOe = 1'h0;
				next_r.st    = ABD_IDLE;
			end
		endcase

		// Acknowledge: float address and parity next cycle, negate busy
		if ((r.st == ABD_MEM_ADDR || r.st == ABD_DS_BEAT1) && ackSeen) begin
			next_r.addrOe = 1'h0;
			next_r.abbOut = 1'h1;
			next_r.done   = 1'h1;
		end

		next_r.addr = driveWord;
		next_r.par  = drivePar;

		// Foreign tenure from its start to its acknowledge
		if (ackSeen) begin
			next_r.othersTen = 1'h0;
		end
		// A new start wins over an acknowledge that closes the previous tenure
		if (otherStart) begin
			next_r.othersTen = 1'h1;
		end

		// Snoop capture only in the start cycle; direct-store beat 0 only
		next_r.capNow    = otherStart;
		next_r.capDirect = ~ext_xfer_start_n_in & ~r.xsOe;
		if (otherStart) begin
			next_r.capAddr = addr_lines_in;
			next_r.capPar  = addr_byte_parity_in;
		end

		// Check in the cycle after start, pull low in the second cycle
		next_r.apeDrive = r.capNow & capBad;
	end

	// ==========================================================
	// State register
	// Reset loads constants only: pins float, strobes read negated
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r.st        <= ABD_IDLE;
			r.addr      <= ABD_RST_ADDR;
			r.par       <= ABD_RST_PAR;
			r.addrOe    <= ABD_RST_OE;
			r.beat1     <= ABD_RST_ADDR;
			r.tsOut     <= ABD_RST_STROBE;
			r.tsOe      <= ABD_RST_OE;
			r.xsOut     <= ABD_RST_STROBE;
			r.xsOe      <= ABD_RST_OE;
			r.abbOut    <= ABD_RST_STROBE;
			r.abbOe     <= ABD_RST_OE;
			r.othersTen <= 1'h0;
			r.capNow    <= 1'h0;
			r.capDirect <= 1'h0;
			r.capAddr   <= ABD_RST_ADDR;
			r.capPar    <= ABD_RST_PAR;
			r.apeDrive  <= 1'h0;
			r.done      <= 1'h0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Pin drive
	// Address and parity share one enable, so they float in the same cycle
	assign addr_lines_out        = r.addr;
	assign addr_lines_oe         = r.addrOe;
	assign addr_byte_parity_out  = r.par;
	assign addr_byte_parity_oe   = r.addrOe;
	assign xfer_start_n_out      = r.tsOut;
	assign xfer_start_n_oe       = r.tsOe;
	assign ext_xfer_start_n_out  = r.xsOut;
	assign ext_xfer_start_n_oe   = r.xsOe;
	assign addr_bus_busy_n_out   = r.abbOut;
	assign addr_bus_busy_n_oe    = r.abbOe;
	// Open drain: only ever drives low, floats on the third cycle
	assign addr_parity_err_n_out = 1'h0;
	assign addr_parity_err_n_oe  = r.apeDrive;

	// ==========================================================
	// Snoop results, valid in the cycle after capture
	// Flags other than snoopAddr mean nothing without snoopValid
	assign snoopValid    = r.capNow;
	assign snoopDirect   = r.capDirect;
	assign snoopAddr     = r.capAddr;
	assign snoopParErr   = r.capNow & capBad;
	// Reply beat carries tags, not an address
	assign snoopReplyHit = r.capNow & r.capDirect
		& (r.capAddr[ABD_RTAG_POS +: TAG_W] == processorTag);
	assign tenureDone    = r.done;

endmodule // abd_addr_phase

// ### dv/abd_addr_phase_assertions.sv
// Purpose: Port checker for the address-phase block.
// Assumes: One bus clock, async active-low reset.
// Notes:   Ports are grouped to keep the checker short.
module abd_addr_phase_assertions
	import abd_pkg::*;
#(
	parameter int TAG_W = ABD_TAG_W  // Processor tag width
) (
	input wire logic clk_sys, resetn, reqValid, reqDirect, reqBurst, reqWrite, reqReady, tenureDone,
	input wire logic snoopValid, snoopReplyHit, addr_ack_n, addr_lines_oe, addr_byte_parity_oe,
	input wire logic addr_bus_busy_n_in, addr_bus_busy_n_out, addr_bus_busy_n_oe, addr_parity_err_n_oe,
	input wire logic xfer_start_n_in, xfer_start_n_out, xfer_start_n_oe,
	input wire logic ext_xfer_start_n_in, ext_xfer_start_n_out, ext_xfer_start_n_oe,
	input wire logic [0:ABD_ADDR_W-1] reqAddr, reqPacket0, snoopAddr, addr_lines_in, addr_lines_out,
	input wire logic [0:ABD_PAR_W-1]  addr_byte_parity_in, addr_byte_parity_out,
	input wire logic [TAG_W-1:0]      processorTag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Helpers
	function automatic logic [0:ABD_PAR_W-1] oddPar(logic [0:ABD_ADDR_W-1] a);
		for (int k = 0; k < ABD_PAR_W; k++)
			oddPar[k] = ~^a[8*k +: 8];
	endfunction
	function automatic logic [0:ABD_ADDR_W-1] align(logic [0:ABD_ADDR_W-1] a, logic b, logic w);
		return !b ? a : (w ? a & 32'hFFFFFFE0 : a & 32'hFFFFFFF8);
	endfunction
	wire ownBeat0  = ext_xfer_start_n_oe && !ext_xfer_start_n_out;  // Own packet 0 on the bus
	wire foreignDs = !ext_xfer_start_n_in && !ext_xfer_start_n_oe;   // Other master, extended start
	wire foreignSt = foreignDs || (!xfer_start_n_in && !xfer_start_n_oe);
	wire parBad    = oddPar(addr_lines_in) != addr_byte_parity_in;    // Even byte on the pins
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ==========================================
	// Properties
	sequence s_memTake; reqValid && reqReady && !reqDirect; endsequence
	sequence s_dsTake; reqValid && reqReady && reqDirect; endsequence
	property p_memDrive;
		s_memTake |=> addr_lines_oe && !xfer_start_n_out && xfer_start_n_oe && !addr_bus_busy_n_out
			&& addr_bus_busy_n_oe && addr_lines_out == align($past(reqAddr), $past(reqBurst), $past(reqWrite));
	endproperty
	a_memDrive: assert property (p_memDrive) else $error("memory address drive wrong");
	property p_dsBeats;
		s_dsTake |=> (ownBeat0 && addr_lines_oe && addr_lines_out == $past(reqPacket0))
			##1 (addr_lines_oe && ext_xfer_start_n_out && addr_lines_out == $past(reqAddr, 2));
	endproperty
	a_dsBeats: assert property (p_dsBeats) else $error("direct-store beats wrong");
	property p_float;
		addr_lines_oe && !addr_ack_n && !ownBeat0 |=> !addr_lines_oe && !addr_byte_parity_oe && tenureDone;
	endproperty
	a_float: assert property (p_float) else $error("address not floated after ack");
	property p_stable;
		addr_lines_oe && $past(addr_lines_oe) && !$past(ownBeat0)
			|-> $stable(addr_lines_out) && $stable(addr_byte_parity_out);
	endproperty
	a_stable: assert property (p_stable) else $error("address changed while driven");
	property p_parity;
		addr_byte_parity_oe == addr_lines_oe && (!addr_lines_oe || addr_byte_parity_out == oddPar(addr_lines_out));
	endproperty
	a_parity: assert property (p_parity) else $error("address parity wrong");
	property p_tsPulse;
		$fell(xfer_start_n_out) |=> xfer_start_n_oe && xfer_start_n_out ##1 !xfer_start_n_oe;
	endproperty
	a_tsPulse: assert property (p_tsPulse) else $error("start strobe shape wrong");
	property p_busyBlock;
		!addr_bus_busy_n_in && !addr_bus_busy_n_oe |-> !reqReady;
	endproperty
	a_busyBlock: assert property (p_busyBlock) else $error("request taken while bus busy");
	property p_snoop;
		foreignSt |=> snoopValid && snoopAddr == $past(addr_lines_in)
			&& snoopReplyHit == ($past(foreignDs) && snoopAddr[ABD_RTAG_POS +: TAG_W] == processorTag);
	endproperty
	a_snoop: assert property (p_snoop) else $error("snoop capture wrong");
	property p_parErr;
		foreignSt |-> ##2 addr_parity_err_n_oe == $past(parBad, 2) ##1 !addr_parity_err_n_oe;
	endproperty
	a_parErr: assert property (p_parErr) else $error("parity error timing wrong");
endmodule // abd_addr_phase_assertions

bind abd_addr_phase abd_addr_phase_assertions #(.TAG_W(TAG_W)) abd_addr_phase_assertions_inst (.*);

// ### dv/abd_bus_partner.sv
// Purpose: Arbiter and memory controller model on the far side of the bus.
// Assumes: Acknowledge delay of one cycle or more.
// Notes:   Acknowledges every tenure, own or foreign.
module abd_bus_partner (
	input  wire logic       clk_sys,     // Bus clock
	input  wire logic       resetn,      // Async reset, active low
	input  wire logic       grantOn,     // Grant the device
	input  wire logic [3:0] ackDelay,    // Start to acknowledge, cycles
	input  wire logic       startLvl_n,  // Resolved start pin
	input  wire logic       extLvl_n,    // Resolved extended start pin
	output logic            bus_grant_n, // Grant pin
	output logic            addr_ack_n   // Acknowledge pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt; // Cycles left before acknowledge
	// ==========================================
	// Grant and acknowledge, changed just after the edge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt         <= 4'h0;
			addr_ack_n  <= 1'h1;
			bus_grant_n <= 1'h1;
		end else begin
			bus_grant_n <= !grantOn;
			if (!startLvl_n || !extLvl_n) begin
				cnt        <= ackDelay - 4'h1;
				addr_ack_n <= ackDelay != 4'h1;
			end else begin
				cnt        <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
				addr_ack_n <= cnt != 4'h1;
			end
		end
	end
endmodule // abd_bus_partner

// ### dv/testbench.sv
// Purpose: Self-checking bench for the address-phase block.
// Assumes: The bench plays the other bus master.
// Notes:   Pins are resolved here from the device's enables.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import abd_pkg::*;
	logic clk_sys, resetn, reqValid, reqDirect, reqBurst, reqWrite, grantOn, fBusy, fTs, fXats;
	logic [0:ABD_ADDR_W-1] reqAddr, reqPacket0, fAddr, snoopAddr, addr_lines_in, addr_lines_out;
	logic [0:ABD_PAR_W-1] fPar, addr_byte_parity_in, addr_byte_parity_out;
	logic [3:0] processorTag, ackDelay;
	logic reqReady, tenureDone, snoopValid, snoopDirect, snoopReplyHit, snoopParErr, bus_grant_n, addr_ack_n;
	logic addr_bus_busy_n_in, addr_bus_busy_n_out, addr_bus_busy_n_oe, xfer_start_n_in, xfer_start_n_out;
	logic xfer_start_n_oe, ext_xfer_start_n_in, ext_xfer_start_n_out, ext_xfer_start_n_oe, addr_lines_oe;
	logic addr_byte_parity_oe, addr_parity_err_n_out, addr_parity_err_n_oe;
	int fails, compares;
	// ==========================================
	// Pin resolution, device drive wins over the bench
	assign addr_bus_busy_n_in  = addr_bus_busy_n_oe ? addr_bus_busy_n_out : fBusy;
	assign xfer_start_n_in     = xfer_start_n_oe ? xfer_start_n_out : fTs;
	assign ext_xfer_start_n_in = ext_xfer_start_n_oe ? ext_xfer_start_n_out : fXats;
	assign addr_lines_in       = addr_lines_oe ? addr_lines_out : fAddr;
	assign addr_byte_parity_in = addr_byte_parity_oe ? addr_byte_parity_out : fPar;
	abd_addr_phase abd_addr_phase_inst (.*);
	abd_bus_partner abd_bus_partner_inst (.clk_sys, .resetn, .grantOn, .ackDelay,
		.startLvl_n(xfer_start_n_in), .extLvl_n(ext_xfer_start_n_in), .bus_grant_n, .addr_ack_n);
	// ==========================================
	// Shared tasks
	function automatic logic [0:3] par(logic [0:31] a);
		for (int k = 0; k < 4; k++)
			par[k] = ~^a[8*k +: 8];
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Own tenure, optionally held off by a foreign busy first
	task automatic t_mem(logic [3:0] d, logic ds, logic b, logic w, logic [0:31] a, int blk);
		logic [0:31] e;
		int n;
		e = ds ? 32'h5A5A0F0F : (!b ? a : a & (w ? 32'hFFFFFFE0 : 32'hFFFFFFF8));
		n = ds;
		@(posedge clk_sys);
		{reqDirect, reqBurst, reqWrite} <= {ds, b, w};
		reqAddr <= a;
		reqPacket0 <= 32'h5A5A0F0F;
		ackDelay <= d;
		fBusy <= blk == 0;
		reqValid <= 1'b1;
		repeat (blk) begin
			@(negedge clk_sys);
			chk("blocked", 32'h0, 32'({reqReady, addr_lines_oe}));
		end
		// Lift the foreign busy after the blocked cycles, then wait for the take
		if (blk != 0) begin
			@(posedge clk_sys);
			fBusy <= 1'b1;
		end
		do @(negedge clk_sys); while (reqReady !== 1'b1);
		// Request is taken at this edge; dropped here so it is taken once
		@(posedge clk_sys);
		reqValid <= 1'b0;
		@(negedge clk_sys);
		chk("lines", e, addr_lines_out);
		chk("parity", 32'(par(e)), 32'(addr_byte_parity_out));
		chk("strobes", 32'h4, 32'({addr_lines_oe, addr_bus_busy_n_out,
			ds ? ext_xfer_start_n_out : xfer_start_n_out}));
		if (ds) begin
			@(negedge clk_sys);
			chk("beat1", a, addr_lines_out);
		end
		do begin
			@(negedge clk_sys);
			n++;
		end while (addr_lines_oe && n < 20);
		chk("float", 32'(d + 1), 32'(n));
		chk("done", 32'hB, 32'({tenureDone, addr_byte_parity_oe,
			addr_bus_busy_n_out, addr_bus_busy_n_oe}));
		@(negedge clk_sys);
		chk("busyOff", 32'h0, 32'({addr_bus_busy_n_oe, xfer_start_n_oe, ext_xfer_start_n_oe}));
		@(posedge clk_sys);
	endtask
	// Foreign start with one beat, then a wrong-parity second beat
	task automatic t_snoop(logic ds, logic bad, logic [0:31] a);
		@(posedge clk_sys);
		ackDelay <= 4'h1;
		fBusy <= 1'b0;
		{fTs, fXats} <= {ds, !ds};
		fAddr <= a;
		fPar <= par(a) ^ {3'h0, bad};
		@(posedge clk_sys);
		{fTs, fXats} <= 2'h3;
		fAddr <= ~a;
		fPar <= ~fPar;
		@(negedge clk_sys);
		chk("snoopFlags", 32'({1'b1, ds, ds && a[28:31] == processorTag, bad}),
			32'({snoopValid, snoopDirect, snoopReplyHit, snoopParErr}));
		chk("snoopAddr", a, snoopAddr);
		@(negedge clk_sys);
		chk("errOn", 32'({bad, 1'b0}), 32'({addr_parity_err_n_oe, addr_parity_err_n_out}));
		@(negedge clk_sys);
		chk("errOff", 32'h0, 32'(addr_parity_err_n_oe));
		@(posedge clk_sys);
		fBusy <= 1'b1;
		fAddr <= a ^ 32'h0F0F0F0F;
	endtask
	// ==========================================
	// Clock, main sequence, watchdog
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		{resetn, reqValid, reqDirect, reqBurst, reqWrite, grantOn} = '0;
		{fBusy, fTs, fXats} = 3'h7;
		{fAddr, fPar, reqAddr, reqPacket0} = '0;
		processorTag = 4'hA;
		ackDelay = 4'h1;
		fails = 0;
		compares = 0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		grantOn <= 1'b1;
		t_mem(4'h1, 1'b0, 1'b0, 1'b0, 32'h80000005, 0);
		t_mem(4'h3, 1'b0, 1'b1, 1'b0, 32'h1234567F, 0);
		t_mem(4'h2, 1'b0, 1'b1, 1'b1, 32'hFFFFFFFF, 3);
		t_mem(4'h1, 1'b1, 1'b0, 1'b0, 32'h0000001C, 0);
		t_mem(4'h4, 1'b1, 1'b0, 1'b0, 32'hA5A5A5A5, 2);
		t_snoop(1'b0, 1'b0, 32'h01020304);
		t_snoop(1'b1, 1'b1, 32'h1234567A);
		t_snoop(1'b1, 1'b0, 32'h12345673);
		t_snoop(1'b0, 1'b1, 32'hFFFFFFFF);
		end_of_test();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
endmodule // testbench
